// ===== hw/pcs_port_cmd.sv
// port command and status register bank with axi4-lite slave and slot rotation
//
// Contract
// [R1] external signal port flag is a strap; when set, external port support reads 1
// [R2] external signal port and hot plug port never both read 1
// [R3] cold presence support strap; when set hot plug port reads 1 (code: only while external signal port is 0)
// [R4] presence switch fitted strap; when set hot plug port reads 1 (code: only while external signal port is 0)
// [R5] hot plug port is a read-only strap for a combined blind-mate connector
// [R6] multiplier attached resets 0, writable only with multiplier support, never set by hardware
// [R7] software sets multiplier attached only while list start is 0
// [R8] cold presence state shows live cold presence detection result
// [R9] command list running resets 0, reads 1 exactly while that engine runs
// [R10] frame receive running resets 0, reads 1 exactly while that engine runs
// [R11] switch state: 1 open, 0 closed; always 0 without switch support
// [R12] software trusts switch state only with support and fitted flags set
// [R13] current slot is read-only and holds the slot being issued while started
// [R14] current slot forced to zero when list start falls
// [R15] after start rises slot 0 has priority, then rotation from slot after current
// [R16] frame receive enable resets 0; while 1 frames may be posted
// [R17] with receive enable 0 frames are rejected except first d2h frame after link init
// [R18] software sets receive enable only after frame base is valid
// [R19] software clears receive enable and waits for not running before moving base
// [R20] list start enables processing; each rise restarts at list entry 0
// [R21] writes to read-only and reserved bits ignored; reserved bits read 0
`timescale 1ns/1ps
`default_nettype none
module pcs_port_cmd (
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	// axi4-lite slave
	input  wire logic [31:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [31:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// straps, captured once after reset release
	input  wire logic        external_signal_port_i,
	input  wire logic        cold_presence_support_i,
	input  wire logic        presence_switch_fitted_i,
	input  wire logic        hot_plug_port_i,
	input  wire logic        multiplier_support_i,
	input  wire logic        presence_switch_support_i,
	input  wire logic        external_port_support_i,
	// live status
	input  wire logic        cold_presence_i,
	input  wire logic        presence_switch_open_i,
	input  wire logic        cmd_list_running_i,
	input  wire logic        frame_rx_running_i,
	// command slot issue
	input  wire logic [31:0] command_issue_i,
	input  wire logic        slot_issued_i,
	// frame receive gate
	input  wire logic        link_init_i,
	input  wire logic        frame_arrive_i,
	input  wire logic        frame_is_d2h_reg_i,
	// outputs to the engines
	output logic             list_start_o,
	output logic             frame_rx_enable_o,
	output logic             multiplier_attached_o,
	output logic             external_port_support_o,
	output logic [4:0]       current_slot_o,
	output logic [4:0]       next_slot_o,
	output logic             next_slot_valid_o,
	output logic             frame_accept_o,
	output logic             frame_reject_o
);

////////////////////////////////////////////////////////////////////////////////
	// first pending slot at or after base, wrapping round
	function automatic logic [5:0] pick_slot(input logic [31:0] pend, input logic [4:0] base);
		logic [5:0] res;
		logic [4:0] idx;
		res = 6'h00;
		for (int k = pcs_pkg::SLOTS - 1; k >= 0; k--) begin
			idx = 5'(base + 5'(k));
			if (pend[idx]) begin
				res = {1'b1, idx};
			end
		end
		return res;
	endfunction

////////////////////////////////////////////////////////////////////////////////
	logic        strap_done;
	logic        ext_port;
	logic        cold_sup;
	logic        sw_fitted;
	logic        hot_plug;
	logic        mult_sup;
	logic        sw_sup;
	logic        list_start;
	logic        start_prev;
	logic        rx_en;
	logic        mult_att;
	logic        cold_state;
	logic        cmd_run;
	logic        rx_run;
	logic        sw_state;
	logic [4:0]  cur_slot;
	logic [4:0]  prio_base;
	logic        first_d2h_open;
	logic        aw_held;
	logic        w_held;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// straps resolved so exclusive flags can never both show: external port wins
	wire         hp_resolve = (hot_plug_port_i | cold_presence_support_i | presence_switch_fitted_i)
	                          & ~external_signal_port_i;                 // [R2] [R3] [R4] [R5]
	wire         do_write   = aw_held && w_held && !s_axi_bvalid_o;
	wire         wr_hit     = (aw_addr == pcs_pkg::PORT_COMMAND_STATUS_ADDR);
	wire         wr_b0      = do_write && wr_hit && w_strb[0];
	wire         wr_b2      = do_write && wr_hit && w_strb[2];
	wire         rd_take    = s_axi_arvalid_i && s_axi_arready_o;
	wire         rd_hit     = (s_axi_araddr_i == pcs_pkg::PORT_COMMAND_STATUS_ADDR);
	wire         start_rise = list_start && !start_prev;
	wire         start_fall = !list_start && start_prev;
	wire [5:0]   choice     = pick_slot(command_issue_i, prio_base);
	wire         gate_open  = rx_en || (first_d2h_open && frame_is_d2h_reg_i);  // [R16] [R17]
	wire [31:0]  reg_value  = {10'h000, ext_port, cold_sup, sw_fitted, hot_plug, mult_att, cold_state,
	                           cmd_run, rx_run, sw_state, cur_slot, 3'h0, rx_en, 3'h0, list_start};  // [R21]

////////////////////////////////////////////////////////////////////////////////
	// straps are sampled on the first edge after reset, never by the reset itself
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			strap_done <= 1'b0;
			ext_port   <= 1'b0;
			cold_sup   <= 1'b0;
			sw_fitted  <= 1'b0;
			hot_plug   <= 1'b0;
			mult_sup   <= 1'b0;
			sw_sup     <= 1'b0;
			external_port_support_o <= 1'b0;
		end else if (!strap_done) begin
			strap_done <= 1'b1;
			ext_port   <= external_signal_port_i;                         // [R1]
			cold_sup   <= cold_presence_support_i;
			sw_fitted  <= presence_switch_fitted_i;
			hot_plug   <= hp_resolve;                                     // [R2]
			mult_sup   <= multiplier_support_i;
			sw_sup     <= presence_switch_support_i;
			external_port_support_o <= external_port_support_i | external_signal_port_i;  // [R1]
		end
	end

	// live status mirrors, one cycle of latency
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cold_state <= 1'b0;
			cmd_run    <= 1'b0;
			rx_run     <= 1'b0;
			sw_state   <= 1'b0;
		end else begin
			cold_state <= cold_presence_i;                                // [R8]
			cmd_run    <= cmd_list_running_i;                             // [R9]
			rx_run     <= frame_rx_running_i;                             // [R10]
			sw_state   <= sw_sup && presence_switch_open_i;               // [R11]
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// software-written bits; hardware itself never sets the multiplier flag
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			list_start <= pcs_pkg::LIST_START_RST;
			rx_en      <= pcs_pkg::FRAME_RX_ENABLE_RST;
			mult_att   <= pcs_pkg::MULT_ATTACHED_RST;
		end else begin
			if (wr_b0) begin
				list_start <= w_data[pcs_pkg::LIST_START_BIT];            // [R20]
				rx_en      <= w_data[pcs_pkg::FRAME_RX_ENABLE_BIT];       // [R16]
			end
			// relies on software not setting it while started
			if (wr_b2 && mult_sup) begin
				mult_att <= w_data[pcs_pkg::MULT_ATTACHED_BIT];           // [R6] [R7]
			end
		end
	end

	// slot pointer: zero on start edges, rotates past each issued slot
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			start_prev <= 1'b0;
			cur_slot   <= pcs_pkg::CUR_SLOT_RST;
			prio_base  <= 5'h00;
		end else begin
			start_prev <= list_start;
			if (start_fall || start_rise) begin
				cur_slot  <= 5'h00;                                       // [R14] [R20]
				prio_base <= 5'h00;                                       // [R15]
			end else if (slot_issued_i && list_start && next_slot_valid_o) begin
				cur_slot  <= next_slot_o;                                 // [R13]
				prio_base <= 5'(next_slot_o + 5'h01);                     // [R15]
			end
		end
	end

	// offered choice is registered, so the engine sees it one cycle after the pending change
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			next_slot_o       <= 5'h00;
			next_slot_valid_o <= 1'b0;
		end else begin
			next_slot_o       <= choice[4:0];                             // [R15]
			next_slot_valid_o <= choice[5] && list_start && !start_rise;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// first d2h frame after link init passes even with receive disabled
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			first_d2h_open <= 1'b0;
			frame_accept_o <= 1'b0;
			frame_reject_o <= 1'b0;
		end else begin
			frame_accept_o <= frame_arrive_i && gate_open;                // [R17]
			frame_reject_o <= frame_arrive_i && !gate_open;               // [R17]
			if (link_init_i) begin
				first_d2h_open <= 1'b1;
			end else if (frame_arrive_i && frame_is_d2h_reg_i) begin
				first_d2h_open <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			list_start_o          <= 1'b0;
			frame_rx_enable_o     <= 1'b0;
			multiplier_attached_o <= 1'b0;
			current_slot_o        <= 5'h00;
		end else begin
			list_start_o          <= list_start;
			frame_rx_enable_o     <= rx_en;
			multiplier_attached_o <= mult_att;
			current_slot_o        <= cur_slot;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// axi4-lite write: address and data held independently, response after both
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 32'h0000_0000;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= pcs_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (do_write) begin
				aw_held        <= 1'b0;
				w_held         <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_hit ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_arready_o <= 1'b0;
		end else begin
			s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o) && !do_write;
			s_axi_wready_o  <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o) && !do_write;
			s_axi_arready_o <= !s_axi_rvalid_o && !rd_take;
		end
	end

	// axi4-lite read: one cycle after the address is taken
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0000_0000;
			s_axi_rresp_o  <= pcs_pkg::RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= rd_hit ? reg_value : 32'h0000_0000;         // [R21]
			s_axi_rresp_o  <= rd_hit ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	excl_flags_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R2]
		!(ext_port && hot_plug)) else $error("external and hot plug flags both set");
	ext_support_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R1]
		strap_done && ext_port |-> external_port_support_o) else $error("external support missing");
	cold_hotplug_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R3] [R4]
		strap_done && (cold_sup || sw_fitted) && !ext_port |-> hot_plug) else $error("hot plug flag missing");
	mult_locked_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R6]
		!mult_sup |=> !mult_att) else $error("multiplier flag changed without support");
	// the edge that releases reset still loads zeros, so mirrors are checked from the next one
	cmd_running_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R9]
		$past(arst_n_i) |-> cmd_run == $past(cmd_list_running_i)) else $error("running flag does not follow engine");
	rx_running_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R10]
		$past(arst_n_i) |-> rx_run == $past(frame_rx_running_i)) else $error("receive running flag wrong");
	switch_zero_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R11]
		!sw_sup |=> !sw_state) else $error("switch state set without support");
	slot_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R14]
		start_fall |=> cur_slot == 5'h00 ##1 current_slot_o == 5'h00) else $error("slot not cleared");
	rx_reject_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R17]
		frame_arrive_i && !rx_en && !frame_is_d2h_reg_i |=> frame_reject_o && !frame_accept_o)
		else $error("frame accepted with receive disabled");
	reserved_zero_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R21]
		s_axi_rvalid_o |-> s_axi_rdata_o[7:5] == 3'h0 && s_axi_rdata_o[3:1] == 3'h0)
		else $error("reserved bits read nonzero");
	rotate_next_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R15]
		slot_issued_i && list_start && next_slot_valid_o && !start_fall && !start_rise
		|=> prio_base == 5'($past(next_slot_o) + 5'h01)) else $error("priority did not rotate");

endmodule
`default_nettype wire

// ===== include/pcs_pkg.sv
// constants for the port command and status register bank
package pcs_pkg;
	localparam logic [31:0] PORT_COMMAND_STATUS_ADDR = 32'h0000_0018;
	localparam int          EXT_SIGNAL_PORT_BIT      = 21;
	localparam int          COLD_PRES_SUPPORT_BIT    = 20;
	localparam int          SWITCH_FITTED_BIT        = 19;
	localparam int          HOT_PLUG_PORT_BIT        = 18;
	localparam int          MULT_ATTACHED_BIT        = 17;
	localparam int          COLD_PRES_STATE_BIT      = 16;
	localparam int          CMD_LIST_RUNNING_BIT     = 15;
	localparam int          FRAME_RX_RUNNING_BIT     = 14;
	localparam int          SWITCH_STATE_BIT         = 13;
	localparam int          CUR_SLOT_LSB             = 8;
	localparam int          FRAME_RX_ENABLE_BIT      = 4;
	localparam int          LIST_START_BIT           = 0;
	localparam int          SLOT_W                   = 5;
	localparam int          SLOTS                    = 32;
	localparam logic        LIST_START_RST           = 1'b0;
	localparam logic        FRAME_RX_ENABLE_RST      = 1'b0;
	localparam logic        MULT_ATTACHED_RST        = 1'b0;
	localparam logic [4:0]  CUR_SLOT_RST             = 5'h00;
	localparam logic [1:0]  RESP_OKAY                = 2'h0;
	localparam logic [1:0]  RESP_SLVERR              = 2'h2;
endpackage

// ===== sim/pcs_port_cmd_test.sv
// self-checking testbench for the port command and status register bank
`timescale 1ns/1ps
`default_nettype none
module pcs_port_cmd_test;
	logic        clk_i = 1'b0, arst_n_i = 1'b0;
	logic [31:0] s_axi_awaddr_i = 32'h0, s_axi_wdata_i = 32'h0, s_axi_araddr_i = 32'h0, command_issue_i = 32'h0;
	logic [3:0]  s_axi_wstrb_i = 4'h0;
	logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
	logic        ext = 1'b0, cold_sup = 1'b0, sw_fit = 1'b0, hp = 1'b0, mps = 1'b0, sws = 1'b0, eps = 1'b0;
	logic        cold = 1'b0, sw_open = 1'b0, cmd_run = 1'b0, rx_run = 1'b0, issued = 1'b0;
	logic        link_init = 1'b0, arrive = 1'b0, is_d2h = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, lst, rxen_o, mult_o, eps_o, nsv, acc, rej;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rd, ci;
	logic [4:0]  cur_o, nxt_o, s, base;
	logic        m_start, m_rxen, m_mult;
	logic [4:0]  m_slot;
	int          n_errors = 0, check_count = 0, seed = 79050, it;

	pcs_port_cmd u_dut (
		.clk_i(clk_i), .arst_n_i(arst_n_i),
		.s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(awready),
		.s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(s_axi_rready_i),
		.external_signal_port_i(ext), .cold_presence_support_i(cold_sup), .presence_switch_fitted_i(sw_fit),
		.hot_plug_port_i(hp), .multiplier_support_i(mps), .presence_switch_support_i(sws),
		.external_port_support_i(eps), .cold_presence_i(cold), .presence_switch_open_i(sw_open),
		.cmd_list_running_i(cmd_run), .frame_rx_running_i(rx_run), .command_issue_i(command_issue_i),
		.slot_issued_i(issued), .link_init_i(link_init), .frame_arrive_i(arrive), .frame_is_d2h_reg_i(is_d2h),
		.list_start_o(lst), .frame_rx_enable_o(rxen_o), .multiplier_attached_o(mult_o),
		.external_port_support_o(eps_o), .current_slot_o(cur_o), .next_slot_o(nxt_o),
		.next_slot_valid_o(nsv), .frame_accept_o(acc), .frame_reject_o(rej));

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic timed_out();
		n_errors++;
		$display("wrong value at %0t: no bus answer", $time);
		stop_test();
	endtask

	// hardware view of the register, built from straps, live inputs and software state
	function automatic logic [31:0] exp_reg();
		logic [31:0] r;
		r = 32'h0;
		r[21] = ext;
		r[20] = cold_sup;
		r[19] = sw_fit;
		r[18] = (hp | cold_sup | sw_fit) & ~ext;
		r[17] = m_mult;
		r[16] = cold;
		r[15] = cmd_run;
		r[14] = rx_run;
		r[13] = sw_open & sws;
		r[12:8] = m_slot;
		r[4] = m_rxen;
		r[0] = m_start;
		return r;
	endfunction

	function automatic logic [4:0] first_pend(input logic [31:0] c, input logic [4:0] b);
		logic [4:0] j;
		for (int k = 0; k < 32; k++) begin
			j = b + k[4:0];
			if (c[j]) return j;
		end
		return 5'h00;
	endfunction

	task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] strb);
		logic aw_d, w_d, got;
		aw_d = 1'b0;
		w_d = 1'b0;
		got = 1'b0;
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_wstrb_i <= strb;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		for (int i = 0; i < 50 && !got; i++) begin
			@(posedge clk_i);
			if (!aw_d && awready === 1'b1) begin
				aw_d = 1'b1;
				s_axi_awvalid_i <= 1'b0;
			end
			if (!w_d && wready === 1'b1) begin
				w_d = 1'b1;
				s_axi_wvalid_i <= 1'b0;
			end
			if (bvalid === 1'b1) begin
				got = 1'b1;
				resp = bresp;
				s_axi_bready_i <= 1'b0;
			end
		end
		if (!got) timed_out();
	endtask

	task automatic axi_read(input logic [31:0] a);
		logic a_d, got;
		a_d = 1'b0;
		got = 1'b0;
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		for (int i = 0; i < 50 && !got; i++) begin
			@(posedge clk_i);
			if (!a_d && arready === 1'b1) begin
				a_d = 1'b1;
				s_axi_arvalid_i <= 1'b0;
			end
			if (rvalid === 1'b1) begin
				got = 1'b1;
				rd = rdata;
				resp = rresp;
				s_axi_rready_i <= 1'b0;
			end
		end
		if (!got) timed_out();
	endtask

	task automatic frame(input logic d2h, input logic exp_acc);
		@(posedge clk_i);
		arrive <= 1'b1;
		is_d2h <= d2h;
		@(posedge clk_i);
		arrive <= 1'b0;
		#1;
		check(32'({acc, rej}), 32'({exp_acc, ~exp_acc}));
	endtask

	task automatic reg_check();
		axi_read(pcs_pkg::PORT_COMMAND_STATUS_ADDR);
		check(rd, exp_reg());
		check(32'(resp), 32'(pcs_pkg::RESP_OKAY));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		for (it = 0; it < 6; it++) begin
			// first pass sets every strap so the conflict resolution is always seen
			{ext, cold_sup, sw_fit, hp, mps, sws, eps} <= (it == 0) ? 7'h7F : 7'($random(seed));
			{m_start, m_rxen, m_mult, m_slot} = 8'h00;
			arst_n_i <= 1'b0;
			repeat (6) @(posedge clk_i);
			arst_n_i <= 1'b1;
			{cold, sw_open, cmd_run, rx_run} <= 4'($random(seed));
			repeat (3) @(posedge clk_i);
			reg_check();
			check(32'(eps_o), 32'(eps | ext));
			// start is still 0 before this write, so setting the multiplier flag is allowed
			axi_write(pcs_pkg::PORT_COMMAND_STATUS_ADDR, 32'hFFFF_FFFF, 4'hF);
			{m_start, m_rxen, m_mult} = {2'b11, mps};
			reg_check();
			check(32'({lst, rxen_o, mult_o}), 32'({m_start, m_rxen, m_mult}));
			// low strobe only: start and receive enable clear, multiplier flag stays
			axi_write(pcs_pkg::PORT_COMMAND_STATUS_ADDR, 32'h0, 4'h1);
			{m_start, m_rxen} = 2'b00;
			reg_check();
		end
		axi_write(32'h0000_0014, 32'hFFFF_FFFF, 4'hF);
		check(32'(resp), 32'(pcs_pkg::RESP_SLVERR));
		axi_read(32'h0000_001C);
		check(rd, 32'h0000_0000);
		check(32'(resp), 32'(pcs_pkg::RESP_SLVERR));
		reg_check();
		ci = $random(seed) | 32'h0000_0003;
		command_issue_i <= ci;
		axi_write(pcs_pkg::PORT_COMMAND_STATUS_ADDR, 32'h1, 4'h1);
		m_start = 1'b1;
		repeat (4) @(posedge clk_i);
		check(32'({nsv, nxt_o}), 32'({1'b1, first_pend(ci, 5'h00)}));
		base = 5'h00;
		repeat (4) begin
			s = first_pend(ci, base);
			@(posedge clk_i);
			issued <= 1'b1;
			@(posedge clk_i);
			issued <= 1'b0;
			repeat (4) @(posedge clk_i);
			base = s + 5'h01;
			check(32'(cur_o), 32'(s));
			check(32'(nxt_o), 32'(first_pend(ci, base)));
		end
		m_slot = s;
		reg_check();
		axi_write(pcs_pkg::PORT_COMMAND_STATUS_ADDR, 32'h0, 4'h1);
		{m_start, m_slot} = 6'h00;
		reg_check();
		check(32'(nsv), 32'h0000_0000);
		axi_write(pcs_pkg::PORT_COMMAND_STATUS_ADDR, 32'h1, 4'h1);
		m_start = 1'b1;
		repeat (4) @(posedge clk_i);
		check(32'({cur_o, nxt_o}), 32'({5'h00, first_pend(ci, 5'h00)}));
		frame(1'b0, 1'b0);
		@(posedge clk_i);
		link_init <= 1'b1;
		@(posedge clk_i);
		link_init <= 1'b0;
		frame(1'b0, 1'b0);
		frame(1'b1, 1'b1);
		frame(1'b1, 1'b0);
		// the receive area lives outside this block and is taken as already programmed
		axi_write(pcs_pkg::PORT_COMMAND_STATUS_ADDR, 32'h10, 4'h1);
		frame(1'b0, 1'b1);
		stop_test();
	end
endmodule
`default_nettype wire
